// File: power_down_clock_out_control.sv
/*
 * power-down and interface clock-output control bank, written over the
 * serial configuration port and driving the power-down enables, the
 * transmit sample hold and the interface clock pins.
 * assumes the clock sources and transmit samples come from logic on
 * ref_clk_in; serial port pins and the port b pin are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
`include "power_down_clock_out_control_map.svh"

module power_down_clock_out_control
    import power_down_clock_out_control_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic sen_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    input wire logic full_duplex_in,
    input wire logic port_b_clock_in,
    input wire logic port_c_clock_in,
    input wire logic port_b_alt_data_in,
    input wire logic port_b_alt_oe_n_in,
    input wire logic interface_port_b_pin_in,
    output logic interface_port_b_pin_out,
    output logic interface_port_b_pin_oe_n_out,
    output logic port_b_pin_sample_out,
    output logic interface_port_c_pin_out,
    input wire logic [`TX_SAMPLE_W-1:0] tx_sample_a_in,
    input wire logic [`TX_SAMPLE_W-1:0] tx_sample_b_in,
    output logic [`TX_SAMPLE_W-1:0] tx_sample_a_out,
    output logic [`TX_SAMPLE_W-1:0] tx_sample_b_out,
    output logic tx_a_output_power_down_out,
    output logic tx_b_output_power_down_out,
    output logic tx_support_power_down_out,
    output logic tx_digital_clock_enable_out,
    output logic rx_digital_power_down_out,
    output logic pll_power_down_out,
    output logic pll_output_disconnect_out,
    output logic pll_relock_out,
    output logic rx_a_core_power_down_out,
    output logic rx_b_core_power_down_out,
    output logic band_gap_enable_out,
    output logic rx_a_dc_bias_power_down_out,
    output logic rx_b_dc_bias_power_down_out,
    output logic rx_bias_power_down_out
);

    // decode one channel of the tx output field; unlisted codes power nothing
    function automatic logic tx_pd_hits(input logic [2:0] code, input logic chan_b);
        logic hit;
        hit = 1'b0;
        unique case (code)
            tx_pd_chan_a: hit = ~chan_b;
            tx_pd_chan_b: hit = chan_b;
            tx_pd_both: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    logic sclk_s; // filtered serial clock
    logic sen_n_s; // filtered serial enable, idles high
    logic sdi_s; // filtered serial data
    logic port_b_pin_s; // filtered port b pin level
    logic [4:0] addr; // register address of the current frame
    logic [7:0] wdata; // byte from a completed write
    logic wr; // one-cycle pulse at write completion
    logic [7:0] rdata; // read-back of the addressed register
    logic soft_reset; // pulse from a soft reset write

    logic [7:0] iface_clock; // interface clock output control
    logic [7:0] power_down; // tx and pll power-down control
    logic [7:0] rx_a_power_down; // rx channel a power-down
    logic [7:0] rx_b_power_down; // rx channel b power-down
    logic [7:0] rx_bias_power_down; // rx bias power-down
    logic [2:0] tx_output_code; // tx output power-down field

    // pins from outside the clock domain; the enable idles released
    input_sync #(
        .WIDTH(4),
        .RESET_VALUE(4'h2)
    ) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .async_in({interface_port_b_pin_in, sdi_in, sen_n_in, sclk_in}),
        .stable_out({port_b_pin_s, sdi_s, sen_n_s, sclk_s})
    );

    // serial configuration port
    serial_port_slave u_serial (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .sclk_in(sclk_s),
        .sen_n_in(sen_n_s),
        .sdi_in(sdi_s),
        .rdata_in(rdata),
        .addr_out(addr),
        .wdata_out(wdata),
        .wr_out(wr),
        .sdo_out(sdo_out),
        .sdo_oe_n_out(sdo_oe_n_out)
    );

    // soft reset decode
    // the command bit is never stored, so it always reads back as zero
    assign soft_reset = wr && addr == `ADDR_GENERAL && wdata[`BIT_SOFT_RESET];

    // read-back; reserved bits and unmapped addresses read zero
    always_comb begin
        unique case (addr)
            `ADDR_IFACE_CLOCK: rdata = iface_clock;
            `ADDR_POWER_DOWN: rdata = power_down;
            `ADDR_RX_A_POWER_DOWN: rdata = rx_a_power_down;
            `ADDR_RX_B_POWER_DOWN: rdata = rx_b_power_down;
            `ADDR_RX_BIAS_POWER_DOWN: rdata = rx_bias_power_down;
            default: rdata = 8'h00;
        endcase
    end

    // interface clock control register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            iface_clock <= `RESET_IFACE_CLOCK;
        end else if (soft_reset) begin
            iface_clock <= `RESET_IFACE_CLOCK;
        end else if (wr && addr == `ADDR_IFACE_CLOCK) begin
            iface_clock <= wdata & `MASK_IFACE_CLOCK;
        end
    end

    // tx and pll power-down register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            power_down <= `RESET_POWER_DOWN;
        end else if (soft_reset) begin
            power_down <= `RESET_POWER_DOWN;
        end else if (wr && addr == `ADDR_POWER_DOWN) begin
            power_down <= wdata & `MASK_POWER_DOWN;
        end
    end

    // per-channel rx power-down registers share one shape
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_a_power_down <= `RESET_RX_POWER_DOWN;
            rx_b_power_down <= `RESET_RX_POWER_DOWN;
        end else if (soft_reset) begin
            rx_a_power_down <= `RESET_RX_POWER_DOWN;
            rx_b_power_down <= `RESET_RX_POWER_DOWN;
        end else if (wr) begin
            if (addr == `ADDR_RX_A_POWER_DOWN) begin
                rx_a_power_down <= wdata & `MASK_RX_POWER_DOWN;
            end
            if (addr == `ADDR_RX_B_POWER_DOWN) begin
                rx_b_power_down <= wdata & `MASK_RX_POWER_DOWN;
            end
        end
    end

    // rx bias power-down register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_bias_power_down <= `RESET_RX_BIAS_POWER_DOWN;
        end else if (soft_reset) begin
            rx_bias_power_down <= `RESET_RX_BIAS_POWER_DOWN;
        end else if (wr && addr == `ADDR_RX_BIAS_POWER_DOWN) begin
            rx_bias_power_down <= wdata & `MASK_RX_BIAS_POWER_DOWN;
        end
    end

    assign tx_output_code = power_down[`BIT_TX_OUTPUT_HI:`BIT_TX_OUTPUT_LO];

    // transmit output power-down enables
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_a_output_power_down_out <= 1'b0;
            tx_b_output_power_down_out <= 1'b0;
            tx_support_power_down_out <= 1'b0;
        end else begin
            tx_a_output_power_down_out <= tx_pd_hits(tx_output_code, 1'b0);
            tx_b_output_power_down_out <= tx_pd_hits(tx_output_code, 1'b1);
            // only the both-channels code also trims the support circuitry
            tx_support_power_down_out <= (tx_output_code == tx_pd_both);
        end
    end

    // transmit digital clock gating and sample hold
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_digital_clock_enable_out <= 1'b1;
            tx_sample_a_out <= '0;
            tx_sample_b_out <= '0;
        end else begin
            tx_digital_clock_enable_out <= ~power_down[`BIT_TX_DIGITAL_PD];
            // hold last samples
            // the hold follows the gate one cycle later, matching the gate flop
            if (tx_digital_clock_enable_out) begin
                tx_sample_a_out <= tx_sample_a_in;
                tx_sample_b_out <= tx_sample_b_in;
            end
        end
    end

    // receive digital and pll controls
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_digital_power_down_out <= 1'b0;
            pll_power_down_out <= 1'b0;
            pll_output_disconnect_out <= 1'b0;
            pll_relock_out <= 1'b0;
        end else begin
            // rx digital power-down
            // blocks that are unused are shut by their own logic as well
            rx_digital_power_down_out <= power_down[`BIT_RX_DIGITAL_PD];
            // pll power-down
            // bypassing relies on the second clock input running at the
            // fastest tx rate, which the board must guarantee
            pll_power_down_out <= power_down[`BIT_PLL_PD];
            // the lock logic never sees this bit, so it keeps locking
            pll_output_disconnect_out <= power_down[`BIT_PLL_OUT_DISCONNECT];
            pll_relock_out <= soft_reset;
        end
    end

    // receive core, dc bias and bias power-downs
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_a_core_power_down_out <= 1'b0;
            rx_b_core_power_down_out <= 1'b0;
            band_gap_enable_out <= 1'b1;
            rx_a_dc_bias_power_down_out <= 1'b0;
            rx_b_dc_bias_power_down_out <= 1'b0;
            rx_bias_power_down_out <= 1'b0;
        end else begin
            rx_a_core_power_down_out <= rx_a_power_down[`BIT_RX_CORE_PD];
            rx_b_core_power_down_out <= rx_b_power_down[`BIT_RX_CORE_PD];
            // band gap kept on
            // channel power-down never reaches it, so wake-up stays quick
            band_gap_enable_out <= 1'b1;
            rx_a_dc_bias_power_down_out <= rx_a_power_down[`BIT_RX_DC_BIAS_PD];
            rx_b_dc_bias_power_down_out <= rx_b_power_down[`BIT_RX_DC_BIAS_PD];
            rx_bias_power_down_out <= rx_bias_power_down[`BIT_RX_BIAS_PD];
        end
    end

    // port b pin: clock output or its other use
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            interface_port_b_pin_out <= 1'b0;
            interface_port_b_pin_oe_n_out <= 1'b1;
            port_b_pin_sample_out <= 1'b0;
        end else begin
            port_b_pin_sample_out <= port_b_pin_s;
            if (iface_clock[`BIT_PORT_B_CLOCK_OUT_ENABLE]) begin
                interface_port_b_pin_out <= port_b_clock_in ^ full_duplex_in;
                interface_port_b_pin_oe_n_out <= 1'b0;
            end else begin
                // otherwise the data path owns the pin
                interface_port_b_pin_out <= port_b_alt_data_in;
                interface_port_b_pin_oe_n_out <= port_b_alt_oe_n_in;
            end
        end
    end

    // port c clock output
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            interface_port_c_pin_out <= 1'b0;
        end else begin
            interface_port_c_pin_out <= port_c_clock_in ^ iface_clock[`BIT_PORT_C_CLOCK_INVERT];
        end
    end

endmodule

`default_nettype wire

// File: power_down_clock_out_control_map.svh
/*
 * register offsets, field positions, reset values and serial frame counts
 * for the power-down and clock-output control bank.
 * assumes it is included by bare name into the design files.
 */
`ifndef POWER_DOWN_CLOCK_OUT_CONTROL_MAP_SVH
`define POWER_DOWN_CLOCK_OUT_CONTROL_MAP_SVH

// register offsets on the serial configuration port
`define ADDR_GENERAL 5'h00
`define ADDR_IFACE_CLOCK 5'h01
`define ADDR_POWER_DOWN 5'h02
`define ADDR_RX_A_POWER_DOWN 5'h03
`define ADDR_RX_B_POWER_DOWN 5'h04
`define ADDR_RX_BIAS_POWER_DOWN 5'h05

// field positions
`define BIT_SOFT_RESET 5
`define BIT_PORT_B_CLOCK_OUT_ENABLE 2
`define BIT_PORT_C_CLOCK_INVERT 1
`define BIT_TX_OUTPUT_HI 7
`define BIT_TX_OUTPUT_LO 5
`define BIT_TX_DIGITAL_PD 4
`define BIT_RX_DIGITAL_PD 3
`define BIT_PLL_PD 2
`define BIT_PLL_OUT_DISCONNECT 1
`define BIT_RX_CORE_PD 7
`define BIT_RX_DC_BIAS_PD 6
`define BIT_RX_BIAS_PD 7

// reset values and writable masks
`define RESET_IFACE_CLOCK 8'h00
`define RESET_POWER_DOWN 8'h00
`define RESET_RX_POWER_DOWN 8'h00
`define RESET_RX_BIAS_POWER_DOWN 8'h00
`define MASK_IFACE_CLOCK 8'h06
`define MASK_POWER_DOWN 8'hfe
`define MASK_RX_POWER_DOWN 8'hc0
`define MASK_RX_BIAS_POWER_DOWN 8'h80

// serial frame: instruction byte then one data byte
`define SERIAL_BYTE_LAST 3'd7
`define TX_SAMPLE_W 12

`endif

// File: power_down_clock_out_control_pkg.sv
/*
 * types shared by the power-down and clock-output control bank.
 * assumes nothing of its surroundings.
 */
package power_down_clock_out_control_pkg;

    // transmit output power-down codes in bits 7 to 5
    typedef enum logic [2:0] {
        tx_pd_none = 3'b000,
        tx_pd_chan_a = 3'b100,
        tx_pd_chan_b = 3'b010,
        tx_pd_both = 3'b111
    } tx_output_pd_t;

    // serial port frame phases
    typedef enum logic [1:0] {
        serial_idle = 2'b00,
        serial_instr = 2'b01,
        serial_data = 2'b10,
        serial_done = 2'b11
    } serial_state_t;

endpackage

// File: input_sync.sv
/*
 * three-stage synchroniser with agreement filter for pin inputs.
 * assumes inputs are asynchronous to ref_clk_in; output follows once
 * the second and third stages agree.
 */
`timescale 1ns/10ps
`default_nettype none

module input_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);

    // one chain per bit; stage one is read by stage two only
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    s1 <= RESET_VALUE[i];
                    s2 <= RESET_VALUE[i];
                    s3 <= RESET_VALUE[i];
                    stable_out[i] <= RESET_VALUE[i];
                end else begin
                    s1 <= async_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    // a change counts only when two stages agree
                    if (s2 == s3) begin
                        stable_out[i] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// File: serial_port_slave.sv
/*
 * serial configuration port slave: 4-wire, msb first, instruction byte
 * (bit 7 read, bits 4..0 address) then one data byte.
 * assumes sclk, enable and data already synchronised to ref_clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
`include "power_down_clock_out_control_map.svh"

module serial_port_slave
    import power_down_clock_out_control_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic sen_n_in,
    input wire logic sdi_in,
    input wire logic [7:0] rdata_in,
    output logic [4:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic sdo_out,
    output logic sdo_oe_n_out
);

    serial_state_t state; // frame phase
    logic sclk_q; // previous sclk level for edge finding
    logic [2:0] count; // bit index within the byte
    logic [7:0] shift_in; // incoming bits
    logic [7:0] shift_out; // outgoing read bits
    logic read_q; // current frame is a read
    logic rise;
    logic fall;

    assign rise = sclk_in & ~sclk_q & ~sen_n_in;
    assign fall = ~sclk_in & sclk_q & ~sen_n_in;

    // edge detector on the filtered clock
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_in;
        end
    end

    // frame sequencing; releasing enable aborts any frame
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= serial_idle;
            count <= 3'd0;
            shift_in <= 8'h00;
            read_q <= 1'b0;
            addr_out <= 5'h00;
            wdata_out <= 8'h00;
            wr_out <= 1'b0;
        end else begin
            wr_out <= 1'b0;
            if (sen_n_in) begin
                state <= serial_idle;
                count <= 3'd0;
            end else begin
                unique case (state)
                    serial_idle: begin
                        state <= serial_instr;
                        count <= 3'd0;
                    end
                    serial_instr: begin
                        if (rise) begin
                            shift_in <= {shift_in[6:0], sdi_in};
                            count <= count + 3'd1;
                            if (count == `SERIAL_BYTE_LAST) begin
                                read_q <= shift_in[6];
                                addr_out <= {shift_in[3:0], sdi_in};
                                state <= serial_data;
                            end
                        end
                    end
                    serial_data: begin
                        if (rise) begin
                            shift_in <= {shift_in[6:0], sdi_in};
                            count <= count + 3'd1;
                            if (count == `SERIAL_BYTE_LAST) begin
                                // the write takes effect when its last bit lands
                                wdata_out <= {shift_in[6:0], sdi_in};
                                wr_out <= ~read_q;
                                state <= serial_done;
                            end
                        end
                    end
                    serial_done: begin
                        // further bits are ignored until enable is released
                        state <= serial_done;
                    end
                endcase
            end
        end
    end

    // read data leaves on falling edges so it is settled for the next rise
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_out <= 8'h00;
            sdo_out <= 1'b0;
            sdo_oe_n_out <= 1'b1;
        end else begin
            sdo_oe_n_out <= ~((state == serial_data) & read_q & ~sen_n_in);
            if (fall && state == serial_data && read_q) begin
                if (count == 3'd0) begin
                    sdo_out <= rdata_in[7];
                    shift_out <= {rdata_in[6:0], 1'b0};
                end else begin
                    sdo_out <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: power_down_clock_out_control_assertions.sv
/*
 checker for the control bank, seeing only the top module ports.
 assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module power_down_clock_out_control_checker (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic sen_n_in,
    input wire logic full_duplex_in,
    input wire logic port_b_clock_in,
    input wire logic port_b_alt_oe_n_in,
    input wire logic interface_port_b_pin_out,
    input wire logic interface_port_b_pin_oe_n_out,
    input wire logic [11:0] tx_sample_a_in,
    input wire logic [11:0] tx_sample_a_out,
    input wire logic [11:0] tx_sample_b_out,
    input wire logic tx_a_output_power_down_out,
    input wire logic tx_b_output_power_down_out,
    input wire logic tx_support_power_down_out,
    input wire logic tx_digital_clock_enable_out,
    input wire logic pll_power_down_out,
    input wire logic pll_relock_out,
    input wire logic rx_a_core_power_down_out,
    input wire logic band_gap_enable_out,
    input wire logic rx_bias_power_down_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // idle cycles of the serial port; long idle means no write can land
    logic [3:0] quiet;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) quiet <= 4'h0;
        else if (!sen_n_in) quiet <= 4'h0;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
    property p_port_b_clk;
        $past(port_b_alt_oe_n_in) && !interface_port_b_pin_oe_n_out
        |-> interface_port_b_pin_out == ($past(port_b_clock_in) ^ $past(full_duplex_in));
    endproperty
    a_port_b_clk: assert property (p_port_b_clk) else $error("port b clock wrong");
    property p_tx_both; tx_support_power_down_out |-> tx_a_output_power_down_out
        && tx_b_output_power_down_out; endproperty
    a_tx_both: assert property (p_tx_both) else $error("tx support without both");
    property p_tx_copy; tx_digital_clock_enable_out |=> tx_sample_a_out == $past(tx_sample_a_in);
    endproperty
    a_tx_copy: assert property (p_tx_copy) else $error("tx sample not copied");
    property p_tx_hold; !tx_digital_clock_enable_out |=> $stable(tx_sample_a_out)
        && $stable(tx_sample_b_out); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx sample moved");
    property p_band_gap; rx_a_core_power_down_out |-> band_gap_enable_out; endproperty
    a_band_gap: assert property (p_band_gap) else $error("band gap off");
    property p_relock_pulse; pll_relock_out |=> !pll_relock_out; endproperty
    a_relock_pulse: assert property (p_relock_pulse) else $error("relock too long");
    property p_relock_clear; pll_relock_out |-> ##[0:2] (!pll_power_down_out
        && !rx_bias_power_down_out && tx_digital_clock_enable_out); endproperty
    a_relock_clear: assert property (p_relock_clear) else $error("soft reset no clear");
    property p_quiet; quiet == 4'hf |-> $stable(pll_power_down_out)
        && $stable(rx_bias_power_down_out) && $stable(tx_digital_clock_enable_out); endproperty
    a_quiet: assert property (p_quiet) else $error("control moved without write");
    c_relock: cover property (pll_relock_out);
    c_tx_off: cover property (!tx_digital_clock_enable_out);
    c_b_clk: cover property (!interface_port_b_pin_oe_n_out && port_b_alt_oe_n_in);
endmodule
bind power_down_clock_out_control power_down_clock_out_control_checker i_chk (.*);
`default_nettype wire

// File: power_down_clock_out_control_tb.sv
/*
 self-checking bench for the control bank over its serial port.
 assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module power_down_clock_out_control_tb
    import power_down_clock_out_control_pkg::*;
;
    logic ref_clk_in = 0, nrst_in = 0, sclk = 0, sen_n = 1, sdi = 0, fd = 0;
    logic bclk = 0, cclk = 0, alt_d = 0, alt_oe_n = 1, bpin = 0;
    logic [11:0] ta = 12'habc, tb_s = 12'h555;
    wire sdo, sdo_oe_n, pb, pb_oe_n, pb_s, pc, relock, bg;
    wire [11:0] qa, qb, pd; // pd: ta tb ts ce rd pp pd ra rb rad rbd rbs
    int err_total = 0, n_checks = 0, relock_n = 0;
    // one row per write: address, data, readback, control outputs
    typedef struct packed {logic [7:0] a, d, rb; logic [11:0] pd;} row_t;
    row_t rows [11] = '{'{8'h02, {tx_pd_both, 5'h0}, 8'he0, 12'hf00},
        '{8'h02, {tx_pd_chan_a, 5'h0}, 8'h80, 12'h900},
        '{8'h02, {tx_pd_chan_b, 5'h0}, 8'h40, 12'h500},
        '{8'h02, 8'h1e, 8'h1e, 12'h0e0}, '{8'h02, 8'h00, 8'h00, 12'h100},
        '{8'h03, 8'hff, 8'hc0, 12'h114}, '{8'h04, 8'h40, 8'h40, 12'h116},
        '{8'h04, 8'h80, 8'h80, 12'h11c}, '{8'h05, 8'hff, 8'h80, 12'h11d},
        '{8'h01, 8'h06, 8'h06, 12'h11d}, '{8'h1f, 8'ha5, 8'h00, 12'h11d}};
    power_down_clock_out_control i_power_down_clock_out_control (.ref_clk_in, .nrst_in,
        .sclk_in(sclk), .sen_n_in(sen_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
        .full_duplex_in(fd), .port_b_clock_in(bclk), .port_c_clock_in(cclk),
        .port_b_alt_data_in(alt_d), .port_b_alt_oe_n_in(alt_oe_n), .interface_port_b_pin_in(bpin),
        .interface_port_b_pin_out(pb), .interface_port_b_pin_oe_n_out(pb_oe_n),
        .port_b_pin_sample_out(pb_s), .interface_port_c_pin_out(pc), .tx_sample_a_in(ta),
        .tx_sample_b_in(tb_s), .tx_sample_a_out(qa), .tx_sample_b_out(qb),
        .tx_a_output_power_down_out(pd[11]), .tx_b_output_power_down_out(pd[10]),
        .tx_support_power_down_out(pd[9]), .tx_digital_clock_enable_out(pd[8]),
        .rx_digital_power_down_out(pd[7]), .pll_power_down_out(pd[6]),
        .pll_output_disconnect_out(pd[5]), .pll_relock_out(relock),
        .rx_a_core_power_down_out(pd[4]), .rx_b_core_power_down_out(pd[3]),
        .band_gap_enable_out(bg), .rx_a_dc_bias_power_down_out(pd[2]),
        .rx_b_dc_bias_power_down_out(pd[1]), .rx_bias_power_down_out(pd[0]));
    initial forever #12.5 ref_clk_in = ~ref_clk_in;
    // relock pulses are counted, the checker judges their width
    always @(posedge ref_clk_in) if (relock === 1'b1) relock_n++;
    task automatic tick(input int n); repeat (n) @(posedge ref_clk_in); endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // serial frame, msb first; halves of 8 cycles outlast the pin synchroniser
    task automatic frame(input logic [15:0] w, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        sen_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            sdi <= w[15-i];
            tick(8);
            if (i > 7) rd = {rd[6:0], sdo};
            sclk <= 1'b1;
            tick(8);
            sclk <= 1'b0;
        end
        tick(8);
        sen_n <= 1'b1;
        tick(12);
    endtask
    initial begin
        logic [7:0] rd;
        tick(6);
        nrst_in <= 1'b1;
        tick(6);
        `CHK("pd reset", 12'h100, pd)
        foreach (rows[i]) begin
            frame({rows[i].a, rows[i].d}, 16, rd);
            `CHK("pd row", rows[i].pd, pd)
            frame({8'h80 | rows[i].a, 8'h00}, 16, rd);
            `CHK("readback", rows[i].rb, rd)
        end
        `CHK("band gap", 1'b1, bg)
        cclk <= 1'b1;
        bclk <= 1'b1;
        tick(3);
        `CHK("port c inv", 1'b0, pc)
        `CHK("port b clk", 2'b10, {pb, pb_oe_n})
        fd <= 1'b1;
        tick(3);
        `CHK("port b fd", 1'b0, pb)
        // samples must freeze while the transmit digital path is down
        frame(16'h0210, 16, rd);
        ta <= 12'h123;
        tick(4);
        `CHK("tx hold", {12'habc, 12'h555}, {qa, qb})
        frame(16'h0200, 16, rd);
        `CHK("tx run", {12'h123, 12'h555}, {qa, qb})
        // a frame cut short must not write
        frame(16'h02ff, 10, rd);
        frame(16'h8200, 16, rd);
        `CHK("abort", 8'h00, rd)
        frame(16'h0020, 16, rd);
        `CHK("soft reset", 12'h100, pd)
        `CHK("relock", 1, relock_n)
        frame(16'h8100, 16, rd);
        `CHK("clk reg", 8'h00, rd)
        alt_oe_n <= 1'b0;
        alt_d <= 1'b1;
        bpin <= 1'b1;
        tick(8);
        `CHK("port b alt", 3'b101, {pb, pb_oe_n, pb_s})
        `CHK("port c plain", 1'b1, pc)
        // hard reset mid-run clears registers and pins at once
        frame(16'h02e0, 16, rd);
        nrst_in <= 1'b0;
        tick(2);
        `CHK("hard reset", {12'h100, 4'hd}, {pd, bg, sdo_oe_n, pb, pb_oe_n})
        nrst_in <= 1'b1;
        tick(6);
        frame(16'h8200, 16, rd);
        `CHK("reset reg", 8'h00, rd)
        tally_and_finish;
    end
    initial begin
        tick(90000);
        err_total++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
